// file: fscg_pkg.sv
// Shared constants for the system clock generator
package fscg_pkg;
   localparam logic [7:0] ADDR_INTEG_LOW = 8'h50;
   localparam logic [7:0] ADDR_INTEG_HIGH = 8'h51;
   localparam logic [7:0] ADDR_FREQ_CTL = 8'h52;
   localparam logic [7:0] ADDR_BUF_CTL = 8'h53;
   localparam logic [6:0] MULT_RESET = 7'h1F;
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   localparam logic [9:0] DCO_LOWEST = 10'h000;
   localparam logic [9:0] DCO_HIGHEST = 10'h3FF;
   localparam int MULT_LSB = 0;
   localparam int MULT_MSB = 6;
   localparam int BUF_SEL_LSB = 0;
   localparam int BUF_SEL_MSB = 1;
   localparam int BUF_EN_BIT = 2;
   typedef enum logic [1:0] {
      FSCG_SEL_AUX,
      FSCG_SEL_AUX_DIV2,
      FSCG_SEL_AUX_DIV4,
      FSCG_SEL_MAIN
   } fscg_sel_t;
endpackage

// file: fscg_top.sv
// System clock generator: crystal clock, locked main clock, clock buffer pin
`timescale 1ns/1ps
// What this block does
// - Auxiliary clock follows the attached 32768 Hz crystal directly.
// - Main clock runs at crystal frequency times multiplier plus one.
// - Power-up clear loads the multiplier field with thirty-one.
// - Power-up clears the oscillator stop bit so the crystal runs.
// - Oscillator stop bit set to one halts crystal and auxiliary clock.
// - Buffer pin carries auxiliary, auxiliary/2, auxiliary/4 or main clock.
// - Loop raises the oscillator setting after short cycles to hold average.
// - Power-up clear sets the controlled oscillator to its lowest frequency.
// - Control logic runs at once after power-up clear, no start condition.
// - Loop corrects the oscillator only with a stable crystal reference.
// - Mode one keeps both clocks but suspends loop control.
// - Mode two stops main clock and loop; auxiliary keeps running.
// - Modes three and four drop oscillator bias; four stops crystal too.
module fscg_top #(
   parameter int DCO_BITS = 10,
   parameter int CNT_BITS = 8
) (
   input wire logic i_clock,
   input wire logic i_rst_n,
   input wire logic i_xtal,
   input wire logic i_dco_tick,
   input wire logic i_osc_stop,
   input wire logic i_loop_disable,
   input wire logic i_main_disable,
   input wire logic i_bias_off,
   input wire logic [7:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [7:0] o_rdata,
   output logic o_aux_clk,
   output logic o_main_clk,
   output logic o_xtal_run,
   output logic o_dco_bias_on,
   output logic [DCO_BITS-1:0] o_dco_setting,
   output logic o_buf_pin
);
   logic xtal_s1_q, xtal_s2_q, xtal_s3_q;
   logic tick_s1_q, tick_s2_q, tick_s3_q;
   logic [6:0] mult_q;
   logic [DCO_BITS-1:0] integ_q, integ_d;
   logic [7:0] buf_ctl_q;
   logic [CNT_BITS-1:0] main_cnt_q, main_cnt_d;
   logic aux_clk_q, main_clk_q, div2_q, buf_q, stable_q;
   logic [1:0] div4_q;
   logic [1:0] stable_cnt_q;
   localparam logic [DCO_BITS-1:0] DCO_HIGHEST_W = '1;

   // Oscillator runs unless software stops it; the deepest-mode term needs the stop bit too
   wire xtal_run = !i_osc_stop && !(i_bias_off && i_main_disable && i_loop_disable
      && i_osc_stop);
   wire main_run = !i_main_disable;
   wire loop_on = !i_loop_disable && main_run && stable_q;
   wire aux_rise = xtal_s2_q && !xtal_s3_q && xtal_run;
   wire dco_rise = tick_s2_q && !tick_s3_q && main_run;
   wire [CNT_BITS-1:0] target = CNT_BITS'(mult_q) + CNT_BITS'(1);
   wire short_cycle = main_cnt_q < target;
   wire long_cycle = main_cnt_q > target;
   wire [1:0] buf_sel = buf_ctl_q[fscg_pkg::BUF_SEL_MSB:fscg_pkg::BUF_SEL_LSB];
   wire buf_en = buf_ctl_q[fscg_pkg::BUF_EN_BIT];
   logic buf_src;

   function automatic logic [DCO_BITS-1:0] step_integ(input logic [DCO_BITS-1:0] v,
                                                      input logic up, input logic dn);
      logic [DCO_BITS-1:0] r;
      r = v;
      if (up && v != {DCO_BITS{1'b1}}) begin
         r = v + DCO_BITS'(1);
      end else if (dn && v != '0) begin
         r = v - DCO_BITS'(1);
      end
      return r;
   endfunction

   // Short measured period means oscillator slow: raise setting, lengthening
   // the average at each rising crystal edge while too-short cycles keep recurring
   always_comb begin
      integ_d = integ_q;
      main_cnt_d = main_cnt_q;
      if (aux_rise) begin
         main_cnt_d = '0;
         if (loop_on) begin
            integ_d = step_integ(integ_q, short_cycle, long_cycle);
         end
      end else if (dco_rise && main_cnt_q != {CNT_BITS{1'b1}}) begin
         main_cnt_d = main_cnt_q + CNT_BITS'(1);
      end
   end

   always_comb begin
      case (fscg_pkg::fscg_sel_t'(buf_sel))
         fscg_pkg::FSCG_SEL_AUX: buf_src = aux_clk_q;
         fscg_pkg::FSCG_SEL_AUX_DIV2: buf_src = div2_q;
         fscg_pkg::FSCG_SEL_AUX_DIV4: buf_src = div4_q[1];
         fscg_pkg::FSCG_SEL_MAIN: buf_src = main_clk_q;
         default: buf_src = 1'b0;
      endcase
   end

   // Pin inputs pass two flops; third stage only feeds edge detection
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         xtal_s1_q <= 1'b0;
         xtal_s2_q <= 1'b0;
         xtal_s3_q <= 1'b0;
         tick_s1_q <= 1'b0;
         tick_s2_q <= 1'b0;
         tick_s3_q <= 1'b0;
      end else begin
         xtal_s1_q <= i_xtal;
         xtal_s2_q <= xtal_s1_q;
         xtal_s3_q <= xtal_s2_q;
         tick_s1_q <= i_dco_tick;
         tick_s2_q <= tick_s1_q;
         tick_s3_q <= tick_s2_q;
      end
   end

   // Loop state starts from power-up values with no extra enable
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         integ_q <= fscg_pkg::DCO_LOWEST[DCO_BITS-1:0];
         main_cnt_q <= '0;
      end else if (i_wr && i_addr == fscg_pkg::ADDR_INTEG_LOW) begin
         integ_q <= {integ_q[DCO_BITS-1:8], i_wdata};
         main_cnt_q <= main_cnt_d;
      end else if (i_wr && i_addr == fscg_pkg::ADDR_INTEG_HIGH) begin
         integ_q <= {i_wdata[DCO_BITS-9:0], integ_q[7:0]};
         main_cnt_q <= main_cnt_d;
      end else begin
         integ_q <= integ_d;
         main_cnt_q <= main_cnt_d;
      end
   end

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         mult_q <= fscg_pkg::MULT_RESET;
         buf_ctl_q <= fscg_pkg::BYTE_ZERO;
      end else if (i_wr && i_addr == fscg_pkg::ADDR_FREQ_CTL) begin
         mult_q <= i_wdata[fscg_pkg::MULT_MSB:fscg_pkg::MULT_LSB];
      end else if (i_wr && i_addr == fscg_pkg::ADDR_BUF_CTL) begin
         buf_ctl_q <= i_wdata;
      end
   end

   // Reference counts as stable after a few crystal edges
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         stable_cnt_q <= 2'h0;
         stable_q <= 1'b0;
      end else if (!xtal_run) begin
         stable_cnt_q <= 2'h0;
         stable_q <= 1'b0;
      end else if (aux_rise) begin
         stable_cnt_q <= (stable_cnt_q == 2'h3) ? stable_cnt_q : stable_cnt_q + 2'h1;
         stable_q <= stable_cnt_q == 2'h3;
      end
   end

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         aux_clk_q <= 1'b0;
         main_clk_q <= 1'b0;
         div2_q <= 1'b0;
         div4_q <= 2'h0;
         buf_q <= 1'b0;
      end else begin
         aux_clk_q <= xtal_run ? xtal_s2_q : 1'b0;
         main_clk_q <= main_run ? tick_s2_q : 1'b0;
         if (aux_rise) begin
            div2_q <= !div2_q;
            div4_q <= div4_q + 2'h1;
         end
         buf_q <= buf_en && buf_src;
      end
   end

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_rdata <= fscg_pkg::BYTE_ZERO;
      end else if (i_rd) begin
         case (i_addr)
            fscg_pkg::ADDR_INTEG_LOW: o_rdata <= integ_q[7:0];
            fscg_pkg::ADDR_INTEG_HIGH: o_rdata <= 8'(integ_q[DCO_BITS-1:8]);
            fscg_pkg::ADDR_FREQ_CTL: o_rdata <= {1'b0, mult_q};
            fscg_pkg::ADDR_BUF_CTL: o_rdata <= buf_ctl_q;
            default: o_rdata <= fscg_pkg::BYTE_ZERO;
         endcase
      end
   end

   assign o_aux_clk = aux_clk_q;
   assign o_main_clk = main_clk_q;
   assign o_xtal_run = xtal_run;
   assign o_dco_bias_on = !i_bias_off;
   assign o_dco_setting = integ_q;
   assign o_buf_pin = buf_q;

   // Clock outputs copy the synchronised pin level one cycle later
   aux_follow_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      xtal_run |=> o_aux_clk == $past(xtal_s2_q)) else $error("aux clock lost the crystal");

   main_follow_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      main_run |=> o_main_clk == $past(tick_s2_q)) else $error("main clock lost the oscillator");

   long_lowers_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      (aux_rise && loop_on && long_cycle && !i_wr && integ_q != '0)
      |=> o_dco_setting == $past(o_dco_setting) - 1'b1) else $error("no lower");

   hold_equal_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      (aux_rise && !short_cycle && !long_cycle && !i_wr)
      |=> $stable(o_dco_setting)) else $error("step on matched period");

   cnt_clear_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      aux_rise |=> main_cnt_q == '0) else $error("period count not cleared");

   cnt_step_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      (!aux_rise && dco_rise && main_cnt_q != {CNT_BITS{1'b1}})
      |=> main_cnt_q == $past(main_cnt_q) + CNT_BITS'(1)) else $error("main tick missed");

   main_off_cnt_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      (!main_run && !aux_rise) |=> $stable(main_cnt_q)) else $error("count runs while off");

   main_off_loop_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      (i_main_disable && !i_wr) |=> $stable(o_dco_setting)) else $error("loop runs while off");

   mult_write_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      (i_wr && i_addr == fscg_pkg::ADDR_FREQ_CTL)
      |=> mult_q == $past(i_wdata[fscg_pkg::MULT_MSB:fscg_pkg::MULT_LSB]))
      else $error("multiplier write lost");

   integ_low_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      (i_wr && i_addr == fscg_pkg::ADDR_INTEG_LOW)
      |=> o_dco_setting[7:0] == $past(i_wdata)) else $error("low integrator write lost");

   integ_high_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      (i_wr && i_addr == fscg_pkg::ADDR_INTEG_HIGH)
      |=> o_dco_setting[DCO_BITS-1:8] == $past(i_wdata[DCO_BITS-9:0]))
      else $error("high integrator write lost");

   rdata_mult_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      (i_rd && i_addr == fscg_pkg::ADDR_FREQ_CTL)
      |=> o_rdata == {1'b0, $past(mult_q)}) else $error("multiplier read wrong");

   div2_step_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      aux_rise |=> div2_q != $past(div2_q)) else $error("half rate divider stuck");

   div4_step_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      aux_rise |=> div4_q == $past(div4_q) + 2'h1) else $error("quarter rate divider stuck");

   buf_main_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      (buf_en && buf_sel == 2'h3) |=> o_buf_pin == $past(main_clk_q))
      else $error("buffer pin lost main clock");

   // Reference must be rebuilt from scratch after any stop
   ref_lost_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      !xtal_run |=> !stable_q) else $error("reference kept while stopped");


   stop_halts_aux_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      i_osc_stop |=> !o_aux_clk) else $error("aux clock runs while stopped");
   main_gated_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      i_main_disable |=> !o_main_clk) else $error("main clock runs while disabled");
   loop_frozen_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      (i_loop_disable && !i_wr) |=> $stable(o_dco_setting)) else $error("loop moved");
   no_ref_frozen_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      (!stable_q && !i_wr) |=> $stable(o_dco_setting)) else $error("unreferenced step");
   short_raises_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      (aux_rise && loop_on && short_cycle && !i_wr && integ_q != DCO_HIGHEST_W)
      |=> o_dco_setting == $past(o_dco_setting) + 1'b1) else $error("no raise");
   buf_off_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      !buf_en |=> !o_buf_pin) else $error("buffer pin active while off");
   bias_follow_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      o_dco_bias_on == !i_bias_off) else $error("bias wrong");
   step_one_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      (!i_wr && !aux_rise) |=> $stable(o_dco_setting)) else $error("stray step");

   raise_c: cover property (@(posedge i_clock) aux_rise && loop_on && short_cycle);
   lower_c: cover property (@(posedge i_clock) aux_rise && loop_on && long_cycle);
   stop_c: cover property (@(posedge i_clock) i_osc_stop);

   hold_c: cover property (@(posedge i_clock) aux_rise && loop_on && !short_cycle && !long_cycle);

   buf_main_c: cover property (@(posedge i_clock) buf_en && buf_sel == 2'h3 && o_buf_pin);
endmodule

// file: fscg_osc_model.sv
// Crystal and controlled oscillator model for the clock generator pins
`timescale 1ns/1ps
module fscg_osc_model #(
   parameter int XTAL_HALF = 32
) (
   input wire logic i_clock,
   input wire logic i_xtal_run,
   input wire logic i_bias_on,
   input wire logic [9:0] i_setting,
   output logic o_xtal,
   output logic o_dco_tick
);
   int xcnt = 0;
   int dcnt = 0;
   int dhalf;
   // Lowest setting gives the slowest oscillator; saturates at one cycle per half
   assign dhalf = (int'(i_setting) > 14) ? 1 : 16 - int'(i_setting);
   initial o_xtal = 1'b0;
   initial o_dco_tick = 1'b0;
   // Stopped crystal stands low, it never runs free while disabled
   always @(negedge i_clock) begin
      xcnt <= (!i_xtal_run || xcnt >= XTAL_HALF - 1) ? 0 : xcnt + 1;
      o_xtal <= i_xtal_run & (o_xtal ^ (xcnt >= XTAL_HALF - 1));
   end
   // Bias off stops the oscillator outright
   always @(negedge i_clock) begin
      dcnt <= (!i_bias_on || dcnt >= dhalf - 1) ? 0 : dcnt + 1;
      o_dco_tick <= i_bias_on & (o_dco_tick ^ (dcnt >= dhalf - 1));
   end
endmodule

// file: test_fscg_top.sv
// Self-checking bench for the system clock generator
`timescale 1ns/1ps
module test_fscg_top;
   logic i_clock = 1'b0;
   logic i_rst_n = 1'b0;
   logic i_osc_stop = 1'b0;
   logic i_loop_disable = 1'b0;
   logic i_main_disable = 1'b0;
   logic i_bias_off = 1'b0;
   logic [7:0] i_addr = 8'h00;
   logic [7:0] i_wdata = 8'h00;
   logic i_wr = 1'b0;
   logic i_rd = 1'b0;
   logic [7:0] o_rdata;
   logic o_aux_clk, o_main_clk, o_xtal_run, o_dco_bias_on, o_buf_pin, i_xtal, i_dco_tick;
   logic [9:0] o_dco_setting;
   logic [9:0] held;
   int miscompares = 0;
   int n_tests = 0;
   int nb, na, nm, e;
   fscg_top DUT (.i_clock, .i_rst_n, .i_xtal, .i_dco_tick, .i_osc_stop, .i_loop_disable,
      .i_main_disable, .i_bias_off, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .o_aux_clk,
      .o_main_clk, .o_xtal_run, .o_dco_bias_on, .o_dco_setting, .o_buf_pin);
   fscg_osc_model MODEL (.i_clock, .i_xtal_run(o_xtal_run), .i_bias_on(o_dco_bias_on),
      .i_setting(o_dco_setting), .o_xtal(i_xtal), .o_dco_tick(i_dco_tick));
   initial forever #50 i_clock = ~i_clock;
   task automatic chk(input logic [9:0] got, input logic [9:0] exp);
      n_tests++;
      if (got !== exp) begin
         miscompares++;
         $display("Error at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask
   task automatic chkn(input int got, input int lo, input int hi);
      n_tests++;
      if (got < lo || got > hi) begin
         miscompares++;
         $display("Error at %0t: count %0h expected %0h to %0h", $time, got, lo, hi);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge i_clock);
      i_addr = a;
      i_wdata = d;
      i_wr = 1'b1;
      @(negedge i_clock);
      i_wr = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(negedge i_clock);
      i_addr = a;
      i_rd = 1'b1;
      @(negedge i_clock);
      i_rd = 1'b0;
      @(negedge i_clock);
      chk({2'b00, o_rdata}, {2'b00, exp});
   endtask
   // Counts rising edges of buffer pin, aux and main clock over n cycles
   task automatic cnt(input int n);
      logic [2:0] p;
      logic [2:0] c;
      p = {o_buf_pin, o_aux_clk, o_main_clk};
      {nb, na, nm} = '0;
      repeat (n) begin
         @(negedge i_clock);
         c = {o_buf_pin, o_aux_clk, o_main_clk};
         nb += int'(c[2] & ~p[2]);
         na += int'(c[1] & ~p[1]);
         nm += int'(c[0] & ~p[0]);
         p = c;
      end
   endtask
   task automatic end_sim;
      $display("Comparisons %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // Watchdog well above the planned run length
   initial begin
      #9000000;
      miscompares++;
      end_sim();
   end
   initial begin
      repeat (8) @(negedge i_clock);
      i_rst_n = 1'b1;
      chk(o_dco_setting, fscg_pkg::DCO_LOWEST);
      chk({9'h000, o_xtal_run}, 10'h001);
      rd(fscg_pkg::ADDR_FREQ_CTL, {1'b0, fscg_pkg::MULT_RESET});
      rd(8'h54, fscg_pkg::BYTE_ZERO);
      cnt(512);
      chkn(na, 7, 9);
      chkn(nm, 1, 512);
      // Four main cycles per crystal period keeps the model's oscillator in range
      wr(fscg_pkg::ADDR_FREQ_CTL, 8'h03);
      cnt(2048);
      cnt(1024);
      chkn(nm, 56, 72);
      chkn(int'(o_dco_setting), 5, 11);
      for (int s = 0; s < 4; s++) begin
         wr(fscg_pkg::ADDR_BUF_CTL, 8'h04 | 8'(s));
         cnt(1024);
         e = (s == 3) ? 4 * 16 : (16 >> s);
         chkn(nb, e - 1, e + 1);
      end
      rd(fscg_pkg::ADDR_BUF_CTL, 8'h07);
      wr(fscg_pkg::ADDR_BUF_CTL, 8'h00);
      cnt(512);
      chkn(nb, 0, 0);
      i_loop_disable = 1'b1;
      held = o_dco_setting;
      cnt(1024);
      chk(o_dco_setting, held);
      chkn(nm, 1, 1024);
      wr(fscg_pkg::ADDR_INTEG_LOW, 8'h34);
      wr(fscg_pkg::ADDR_INTEG_HIGH, 8'hFF);
      rd(fscg_pkg::ADDR_INTEG_HIGH, 8'h03);
      rd(fscg_pkg::ADDR_INTEG_LOW, 8'h34);
      chk(o_dco_setting, 10'h334);
      wr(fscg_pkg::ADDR_INTEG_HIGH, 8'h00);
      wr(fscg_pkg::ADDR_INTEG_LOW, 8'h08);
      i_loop_disable = 1'b0;
      i_main_disable = 1'b1;
      held = o_dco_setting;
      cnt(1024);
      chkn(nm, 0, 0);
      chkn(na, 15, 17);
      chk(o_dco_setting, held);
      i_bias_off = 1'b1;
      @(negedge i_clock);
      chk({9'h000, o_dco_bias_on}, 10'h000);
      i_osc_stop = 1'b1;
      @(negedge i_clock);
      chk({9'h000, o_xtal_run}, 10'h000);
      cnt(512);
      chkn(na, 0, 0);
      {i_osc_stop, i_bias_off, i_main_disable} = 3'b000;
      cnt(512);
      chkn(na, 7, 9);
      wr(fscg_pkg::ADDR_FREQ_CTL, 8'h05);
      rd(fscg_pkg::ADDR_FREQ_CTL, 8'h05);
      i_rst_n = 1'b0;
      @(negedge i_clock);
      i_rst_n = 1'b1;
      chk(o_dco_setting, fscg_pkg::DCO_LOWEST);
      rd(fscg_pkg::ADDR_FREQ_CTL, {1'b0, fscg_pkg::MULT_RESET});
      end_sim();
   end
endmodule
